// File: cos_can_status.v
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "cos_map.vh"

module cos_can_status #(
  parameter OBJ_COUNT = 32
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  // message interface set (software access to objects)
  input wire ifValidWrite,
  input wire ifPendWrite,
  input wire [4:0] ifObjNum,
  input wire ifValidData,
  input wire ifPendData,
  // message handler
  input wire [31:0] hdlPendSet,
  input wire [31:0] hdlPendClr,
  output reg [31:0] objectValid,
  output reg [31:0] objectIrqPending,
  // bus receive pin and wake-up
  input wire canRx,
  output reg wakeEvent,
  output reg wakeFlag,
  // interrupt
  output wire irq
);

  // overview: the bus side decodes one word per register and inserts
  // one wait state on reads only; the object side keeps the valid and
  // pending flags as mirrors written by the interface set, the pending flags also by the
  // handler; the wake side watches the receive pin through a two-flop
  // synchroniser and keeps a sticky flag for software

  // ahb data-phase state
  reg dataWrite;
  reg dataRead;
  reg readWait;
  reg [11:0] dataAddr;

  // software-visible control
  reg wakeEnable;
  reg [`COS_IRQ_BITS-1:0] irqStatus;
  reg [`COS_IRQ_BITS-1:0] irqMask;

  // rx pin synchroniser and edge history
  reg rxMeta;
  reg rxSync;
  reg rxLast;

  // next values
  reg [31:0] next_pend;
  reg [31:0] next_valid;
  reg [31:0] next_rdata;
  reg [`COS_IRQ_BITS-1:0] next_irqStatus;

  wire addrPhase;
  wire regWrite;
  wire rxFall;
  wire wakeHit;
  wire pendRise;
  wire [`COS_IRQ_BITS-1:0] irqEvents;
  wire [31:0] handlerSet;

  // register selects and write strobes from the data-phase address
  wire selPendLow;
  wire selPendHigh;
  wire selValidLow;
  wire selValidHigh;
  wire selWakeEn;
  wire selWakeSts;
  wire selIrqSts;
  wire selIrqMask;
  wire wakeEnWrite;
  wire wakeClearWrite;
  wire irqClearWrite;
  wire irqMaskWrite;

  // per-register read values, reserved bits already zero
  wire [31:0] rdPendLow;
  wire [31:0] rdPendHigh;
  wire [31:0] rdValidLow;
  wire [31:0] rdValidHigh;
  wire [31:0] rdWakeEn;
  wire [31:0] rdWakeSts;
  wire [31:0] rdIrqSts;
  wire [31:0] rdIrqMask;

  // pending flags after the interface write, before the handler
  reg [31:0] pendAfterIf;

  // a transfer is taken only on an active cycle with hready high;
  // idle and busy cycles leave the following data phase empty
  assign addrPhase = hsel & hready & htrans[1];
  assign regWrite = dataWrite;

  // register decode on the low twelve address bits only; the block
  // therefore repeats every 4 KB, which keeps the compare small
  assign selPendLow = (dataAddr == `COS_OFS_PEND_LOW);
  assign selPendHigh = (dataAddr == `COS_OFS_PEND_HIGH);
  assign selValidLow = (dataAddr == `COS_OFS_VALID_LOW);
  assign selValidHigh = (dataAddr == `COS_OFS_VALID_HIGH);
  assign selWakeEn = (dataAddr == `COS_OFS_WAKE_EN);
  assign selWakeSts = (dataAddr == `COS_OFS_WAKE_STS);
  assign selIrqSts = (dataAddr == `COS_OFS_IRQ_STS);
  assign selIrqMask = (dataAddr == `COS_OFS_IRQ_MASK);

  // write strobes; a register without one ignores writes, which is
  // what keeps the pending and valid mirrors read-only
  assign wakeEnWrite = regWrite & selWakeEn;
  assign wakeClearWrite = regWrite & selWakeSts & ~hwdata[`COS_BIT_WAKE_FLAG];
  assign irqClearWrite = regWrite & selIrqSts;
  assign irqMaskWrite = regWrite & selIrqMask;

  // reads insert one wait state so data comes from a flop and
  // always reflects a write that finished in the cycle before;
  // writes take no wait state, the register updates as the data
  // phase ends
  assign hreadyout = ~(dataRead & ~readWait);
  assign hresp = `COS_HRESP_OKAY;

  // address capture; a read or write is remembered for its data phase
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dataWrite <= 1'b0;
      dataRead <= 1'b0;
      dataAddr <= 12'h000;
    end else if (hreadyout) begin
      dataWrite <= addrPhase & hwrite;
      dataRead <= addrPhase & ~hwrite;
      if (addrPhase) begin
        dataAddr <= haddr[11:0];
      end
    end
  end

  // wait-state marker: set in the first read data cycle, dropped when
  // the bus moves on; it keeps hreadyout low for exactly one cycle
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readWait <= 1'b0;
    end else if (hreadyout) begin
      readWait <= 1'b0;
    end else begin
      readWait <= 1'b1;
    end
  end

  // two-flop synchroniser on the receive pin; the edge is taken
  // from the second and third stage so the first is never read;
  // the price is three cycles from pin to flag, far below a bus bit
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxLast <= 1'b1;
    end else begin
      rxMeta <= canRx;
      rxSync <= rxMeta;
      rxLast <= rxSync;
    end
  end

  // falling edge between the two newest synchronised samples; the
  // reset value of one matches the idle bus, so reset makes no edge
  assign rxFall = rxLast & ~rxSync;
  // the enable gates the edge itself, so an edge seen while disabled
  // is dropped rather than remembered for later
  assign wakeHit = wakeEnable & rxFall;

  // handler updates are dropped for objects not marked valid; the
  // handler treats such an object as absent
  assign handlerSet = hdlPendSet & objectValid;

  // object valid flags: only the interface set changes them; the bus
  // has no write path here, and the handler never writes them
  always @* begin
    next_valid = objectValid;
    if (ifValidWrite) begin
      next_valid[ifObjNum] = ifValidData;
    end
  end

  // pending flags, first stage: the interface set writes one object
  always @* begin
    pendAfterIf = objectIrqPending;
    if (ifPendWrite) begin
      pendAfterIf[ifObjNum] = ifPendData;
    end
  end

  // second stage: handler clear, then handler set; a set that meets
  // any clear in the same cycle wins, so no completion is lost
  always @* begin
    next_pend = pendAfterIf & ~(hdlPendClr & objectValid);
    next_pend = next_pend | handlerSet;
  end

  // any flag rising this cycle is one interrupt event
  assign pendRise = |(next_pend & ~objectIrqPending);

  // flag registers; both take their next values on every clock
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      objectValid <= `COS_RST_WORD;
      objectIrqPending <= `COS_RST_WORD;
    end else begin
      objectValid <= next_valid;
      objectIrqPending <= next_pend;
    end
  end

  // wake event pulse, one cycle per enabled falling edge
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakeEvent <= 1'b0;
    end else begin
      wakeEvent <= wakeHit;
    end
  end

  // wake enable, plain read/write bit, zero from reset
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakeEnable <= 1'b0;
    end else if (wakeEnWrite) begin
      wakeEnable <= hwdata[`COS_BIT_WAKE_EN];
    end
  end

  // sticky wake flag; a new edge beats a clear in the same cycle, so
  // software never loses an edge that lands while it is clearing;
  // writing a one leaves the flag alone
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakeFlag <= 1'b0;
    end else if (wakeHit) begin
      wakeFlag <= 1'b1;
    end else if (wakeClearWrite) begin
      wakeFlag <= 1'b0;
    end
  end

  // interrupt status: sticky events, write one to clear, set wins
  assign irqEvents = {pendRise, wakeHit};

  // next status: clear by writing ones, then or in the new events
  always @* begin
    next_irqStatus = irqStatus;
    if (irqClearWrite) begin
      next_irqStatus = irqStatus & ~hwdata[`COS_IRQ_BITS-1:0];
    end
    next_irqStatus = next_irqStatus | irqEvents;
  end

  // status bits; the event is or-ed in after the clear so set wins
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= `COS_RST_IRQ;
    end else begin
      irqStatus <= next_irqStatus;
    end
  end

  // interrupt mask, same layout as the status bits
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqMask <= `COS_RST_IRQ;
    end else if (irqMaskWrite) begin
      irqMask <= hwdata[`COS_IRQ_BITS-1:0];
    end
  end

  // level output, high while any unmasked status bit stands; it is
  // built from flops only, so bus activity cannot glitch it
  assign irq = |(irqStatus & irqMask);

  // read values; only the defined field is placed, so every reserved
  // bit returns zero whatever software wrote there
  assign rdPendLow = {16'h0000, objectIrqPending[15:0]};
  assign rdPendHigh = {16'h0000, objectIrqPending[31:16]};
  assign rdValidLow = {16'h0000, objectValid[15:0]};
  assign rdValidHigh = {16'h0000, objectValid[31:16]};
  assign rdWakeEn = {31'h0000_0000, wakeEnable};
  assign rdWakeSts = {31'h0000_0000, wakeFlag};
  assign rdIrqSts = {30'h0000_0000, irqStatus};
  assign rdIrqMask = {30'h0000_0000, irqMask};

  // read mux; an unmapped address falls through to zero
  always @* begin
    next_rdata = `COS_RST_WORD;
    if (selPendLow) begin
      next_rdata = rdPendLow;
    end else if (selPendHigh) begin
      next_rdata = rdPendHigh;
    end else if (selValidLow) begin
      next_rdata = rdValidLow;
    end else if (selValidHigh) begin
      next_rdata = rdValidHigh;
    end else if (selWakeEn) begin
      next_rdata = rdWakeEn;
    end else if (selWakeSts) begin
      next_rdata = rdWakeSts;
    end else if (selIrqSts) begin
      next_rdata = rdIrqSts;
    end else if (selIrqMask) begin
      next_rdata = rdIrqMask;
    end
  end

  // read data is loaded during the wait cycle of a read; it then
  // holds until the next read, so later writes cannot disturb it
  // while the master is still taking it
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= `COS_RST_WORD;
    end else if (dataRead && !readWait) begin
      hrdata <= next_rdata;
    end
  end

endmodule

// File: cos_can_status_props.sv
`timescale 1ns/1ps
module cos_can_status_props (
  // bus side
  input wire core_clk, nrst, hsel, hwrite, hready, hreadyout,
  input wire [1:0] htrans,
  input wire [31:0] hrdata,
  // object side
  input wire ifValidWrite, ifValidData, ifPendWrite,
  input wire [4:0] ifObjNum,
  input wire [31:0] hdlPendSet, objectValid, objectIrqPending,
  // wake side
  input wire canRx, wakeEvent, wakeFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // address phase taken, then one wait cycle before read data
  sequence taken(w);
    hsel && hready && htrans[1] && hwrite == w;
  endsequence
  sequence rdAns;
    !hreadyout ##1 (hreadyout && hrdata[31:16] == 16'h0000);
  endsequence
  chk_upper_zero: assert property (taken(1'b0) |=> rdAns)
    else $error("read upper half not zero");
  chk_valid_write: assert property (ifValidWrite |=>
    objectValid[$past(ifObjNum)] == $past(ifValidData)) else $error("valid write lost");
  chk_valid_hold: assert property (!ifValidWrite |=> $stable(objectValid))
    else $error("valid changed alone");
  chk_pend_gate: assert property (!objectValid[16] && !ifPendWrite |=>
    $stable(objectIrqPending[16])) else $error("invalid object pending moved");
  chk_pend_set: assert property (hdlPendSet[31] && objectValid[31] |=>
    objectIrqPending[31]) else $error("pending not set");
  chk_event_flag: assert property (wakeEvent |-> wakeFlag)
    else $error("flag missing on event");
  chk_flag_sticky: assert property (wakeFlag &&
    !$past(hsel && hready && htrans[1] && hwrite) |=> wakeFlag) else $error("flag dropped");
  chk_rx_cause: assert property (wakeEvent |-> $past(canRx, 2) == 1'b0)
    else $error("event without rx low");
endmodule

// File: cos_can_status_tb.sv
`timescale 1ns/1ps
`define CHK(n,e,s) check_count++; if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end
module cos_can_status_tb;
  logic core_clk, nrst, hsel, hwrite, ifValidWrite, ifValidData;
  logic [31:0] haddr, hwdata, hdlPendSet, hdlPendClr, q;
  logic [1:0] htrans;
  logic [4:0] ifObjNum;
  logic [11:0] ad [6] = '{12'h144, 12'h160, 12'h164, 12'h168, 12'h16c, 12'h200};
  wire hreadyout, hresp, canRx, wakeEvent, wakeFlag, irq;
  wire [31:0] hrdata, objectValid, objectIrqPending;
  int n_errors = 0;
  int check_count = 0;
  int n_wake = 0;
  // count wake pulses as the design shows them
  always @(posedge core_clk) if (wakeEvent === 1'b1) n_wake++;
  cos_can_status u_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ifValidWrite(ifValidWrite),
    .ifPendWrite(1'b0), .ifObjNum(ifObjNum), .ifValidData(ifValidData), .ifPendData(1'b0),
    .hdlPendSet(hdlPendSet), .hdlPendClr(hdlPendClr), .objectValid(objectValid),
    .objectIrqPending(objectIrqPending), .canRx(canRx), .wakeEvent(wakeEvent),
    .wakeFlag(wakeFlag), .irq(irq));
  cos_rx_model u_rx (.core_clk(core_clk), .canRx(canRx));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // hready looked at mid-cycle, where nothing is moving
  task w8;
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge core_clk);
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
    hsel <= 1'b1; haddr <= {20'h0, a}; hwrite <= w; htrans <= 2'h2;
    w8;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    w8;
  endtask
  task rc(input [11:0] a, input [31:0] e);
    xf(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, q)
  endtask
  // spare edge keeps strobes from being set twice in one step
  task ob(input [4:0] n);
    ifObjNum <= n; ifValidData <= 1'b1; ifValidWrite <= 1'b1;
    @(posedge core_clk); ifValidWrite <= 1'b0; @(posedge core_clk);
  endtask
  task hd(input [31:0] s, input [31:0] c);
    hdlPendSet <= s; hdlPendClr <= c;
    @(posedge core_clk); hdlPendSet <= '0; hdlPendClr <= '0; @(posedge core_clk);
  endtask
  task ck(input e);
    @(negedge core_clk); `CHK("irq", e, irq) @(posedge core_clk);
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {nrst, hsel, hwrite, ifValidWrite, ifValidData, htrans, ifObjNum} = '0;
    {haddr, hwdata, hdlPendSet, hdlPendClr} = '0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (ad[i]) rc(ad[i], 32'h0);
    $display("test reset done");
    ob(5'd0); ob(5'd31); xf(1'b1, 12'h160, 32'h0000_ffff);
    `CHK("objectValid", 32'h8000_0001, objectValid)
    `CHK("hresp", 1'b0, hresp)
    rc(12'h160, 32'h1);
    rc(12'h164, 32'h8000);
    hd(32'h8001_0001, 32'h0);
    `CHK("objectIrqPending", 32'h8000_0001, objectIrqPending)
    rc(12'h144, 32'h8000);
    rc(12'h140, 32'h1);
    hd(32'h0, 32'h8000_0000);
    rc(12'h144, 32'h0);
    $display("test objects done");
    xf(1'b1, 12'h174, 32'h3); xf(1'b1, 12'h168, 32'h1);
    rc(12'h168, 32'h1);
    xf(1'b1, 12'h170, 32'h3); ck(1'b0);
    u_rx.fall; u_rx.fall; ck(1'b1);
    `CHK("wakeFlag", 1'b1, wakeFlag)
    xf(1'b1, 12'h16c, 32'h1); rc(12'h16c, 32'h1);
    xf(1'b1, 12'h170, 32'h3); ck(1'b0);
    xf(1'b1, 12'h16c, 32'h0); rc(12'h16c, 32'h0);
    xf(1'b1, 12'h168, 32'h0); u_rx.fall; rc(12'h16c, 32'h0);
    `CHK("wake events", 2, n_wake)
    $display("test wake done");
    close_out;
  end
  // hang guard, far beyond the hundred or so cycles used
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
bind cos_can_status cos_can_status_props u_chk (.*);

// File: cos_map.vh
`ifndef COS_MAP_VH
`define COS_MAP_VH

// register byte offsets
`define COS_OFS_PEND_LOW 12'h140
`define COS_OFS_PEND_HIGH 12'h144
`define COS_OFS_VALID_LOW 12'h160
`define COS_OFS_VALID_HIGH 12'h164
`define COS_OFS_WAKE_EN 12'h168
`define COS_OFS_WAKE_STS 12'h16c
`define COS_OFS_IRQ_STS 12'h170
`define COS_OFS_IRQ_MASK 12'h174

// field positions
`define COS_BIT_WAKE_EN 0
`define COS_BIT_WAKE_FLAG 0
`define COS_BIT_IRQ_WAKE 0
`define COS_BIT_IRQ_PEND 1

// widths and reset values
`define COS_IRQ_BITS 2
`define COS_RST_WORD 32'h0000_0000
`define COS_RST_HALF 16'h0000
`define COS_RST_IRQ 2'h0

// ahb-lite codes
`define COS_HTRANS_NONSEQ 2'h2
`define COS_HTRANS_SEQ 2'h3
`define COS_HRESP_OKAY 1'h0

`endif

// File: cos_rx_model.sv
`timescale 1ns/1ps
// receive line, recessive high between frames
module cos_rx_model (
  input wire core_clk,
  output logic canRx
);
  initial canRx = 1'b1;
  // dominant long enough to pass the two-flop sync
  task automatic fall;
    canRx <= 1'b0;
    repeat (4) @(posedge core_clk);
    canRx <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule
